// ---- mpw_detector.sv ----
// module: magic packet wake detector on a 4-bit nibble stream
`default_nettype none

// Summary of operation
// [RQ1] Active-low reset returns recognizer to idle with no pulse pending.
// [RQ2] Nibbles are sampled only while the nibble-valid input is high.
// [RQ3] Twelve consecutive all-ones nibbles form the 48-bit sync run.
// [RQ4] Any failed nibble comparison drops the attempt and returns to idle.
// [RQ5] After sync, each address nibble is compared with the stored address.
// [RQ6] A fully matched address increments the repetition counter by one.
// [RQ7] Wake needs 16 consecutive matching addresses right after the sync run.
// [RQ8] At count 16 the wake output pulses high for exactly one clock.
// [RQ9] Client address is a design constant or supplied at power-up.
// [RQ10] 47 ones then a zero never produces a wake pulse.
// [RQ11] Wrong addresses after good sync never produce a wake pulse.
// [RQ12] All frames are watched; only own-address patterns wake.
// [RQ13] Address nibbles compared in wire order, low nibble of each byte first.
// [RQ14] Mismatch or valid dropping clears counter and position, back to idle.
module mpw_detector
	import mpw_pkg::*;
#(
	parameter logic [47:0] CLIENT_ADDR = DEFAULT_ADDR
)
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// monitored nibble interface
	input  wire logic [3:0] monitored_nibble,
	input  wire logic       monitored_nibble_valid,
	// wake output to system controller
	output logic            wake_interrupt_pulse
);
	// ----------------------------------------
	// state and counters
	// ----------------------------------------
	mpw_state_t state;
	logic [3:0] pos;
	logic [4:0] rep_cnt;
	logic       addr_match;
	logic       sync_ok;
	logic       addr_done;

	mpw_nibble_cmp u_cmp (
		.station_addr (CLIENT_ADDR), // [RQ9]
		.pos          (pos),
		.nibble       (monitored_nibble),
		.match        (addr_match)
	);

	assign sync_ok   = (monitored_nibble == SYNC_NIBBLE);
	assign addr_done = addr_match && (pos == POS_LAST);

	// ----------------------------------------
	// recognizer
	// ----------------------------------------
	// a frame ends with valid low, so any attempt still open is abandoned there
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state   <= MPW_IDLE; // [RQ1]
			pos     <= POS_ZERO;
			rep_cnt <= CNT_ZERO;
		end else if (!monitored_nibble_valid) begin
			state   <= MPW_IDLE; // [RQ2] [RQ14]
			pos     <= POS_ZERO;
			rep_cnt <= CNT_ZERO;
		end else begin
			unique case (state)
				MPW_IDLE, MPW_SYNC: begin
					if (sync_ok) begin // [RQ3]
						if (pos == POS_LAST) begin
							state <= MPW_ADDR;
							pos   <= POS_ZERO;
						end else begin
							state <= MPW_SYNC;
							pos   <= pos + POS_ONE;
						end
					end else begin
						state <= MPW_IDLE; // [RQ4] [RQ10]
						pos   <= POS_ZERO;
					end
					rep_cnt <= CNT_ZERO;
				end
				MPW_ADDR: begin
					if (!addr_match) begin
						state   <= MPW_IDLE; // [RQ4] [RQ11] [RQ14]
						pos     <= POS_ZERO;
						rep_cnt <= CNT_ZERO;
					end else if (addr_done) begin
						pos <= POS_ZERO;
						if (rep_cnt + CNT_ONE == CNT_DONE) begin
							state   <= MPW_IDLE; // [RQ7]
							rep_cnt <= CNT_ZERO;
						end else begin
							rep_cnt <= rep_cnt + CNT_ONE; // [RQ6]
						end
					end else begin
						pos <= pos + POS_ONE; // [RQ5]
					end
				end
				default: begin
					state   <= MPW_IDLE;
					pos     <= POS_ZERO;
					rep_cnt <= CNT_ZERO;
				end
			endcase
		end
	end

	// ----------------------------------------
	// wake pulse
	// ----------------------------------------
	// registered, so it is high exactly one clock after the last address nibble
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wake_interrupt_pulse <= 1'b0; // [RQ1]
		end else begin
			wake_interrupt_pulse <= monitored_nibble_valid && (state == MPW_ADDR)
				&& addr_done && (rep_cnt + CNT_ONE == CNT_DONE); // [RQ8] [RQ12]
		end
	end
endmodule // mpw_detector
`default_nettype wire

// ---- mpw_detector_props.sv ----
// checker: wake pulse timing and its place in the nibble stream
`default_nettype none
module mpw_detector_props import mpw_pkg::*; #(parameter logic [47:0] CLIENT_ADDR = DEFAULT_ADDR) (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [3:0] monitored_nibble,
	input wire logic       monitored_nibble_valid,
	input wire logic       wake_interrupt_pulse
);
	timeunit 1ns / 1ps;
	wire logic       p = wake_interrupt_pulse;
	wire logic [3:0] n = monitored_nibble;
	logic      [7:0] run;
	// saturates so a long valid stream never wraps back into range
	always_ff @(posedge clk)
		run <= (!rst_n || !monitored_nibble_valid) ? 8'h00 : run + {7'h00, run != 8'hff};
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_reset_quiet: assert property (
		$rose(rst_n) |-> !p) else $error("pulse at reset");
	chk_pulse_single: assert property (
		p |=> !p) else $error("long pulse");
	chk_valid_run: assert property (
		p |-> run >= 8'hcc) else $error("short run");
	chk_last_nibble: assert property (
		p |-> $past(n) == CLIENT_ADDR[7:4]) else $error("last");
	chk_low_first: assert property (
		p |-> $past(n, 2) == CLIENT_ADDR[3:0]) else $error("low");
	chk_sync_end: assert property (
		p |-> $past(n, 193) == 4'hf) else $error("sync");
	chk_first_addr: assert property (
		p |-> $past(n, 192) == CLIENT_ADDR[43:40]) else $error("a1");
	chk_second_rep: assert property (
		p |-> $past(n, 180) == CLIENT_ADDR[43:40]) else $error("a2");
endmodule // mpw_detector_props
bind mpw_detector mpw_detector_props #(.CLIENT_ADDR(CLIENT_ADDR)) u_props (.clk(clk), .rst_n(rst_n),
	.monitored_nibble(monitored_nibble), .monitored_nibble_valid(monitored_nibble_valid),
	.wake_interrupt_pulse(wake_interrupt_pulse));
`default_nettype wire

// ---- mpw_detector_test.sv ----
// testbench: wake detector fed by the physical layer model
`default_nettype none
module mpw_detector_test import mpw_pkg::*; ;
	timeunit 1ns / 1ps;
	logic       clk = 1'b0, rst_n = 1'b0, wake, vld;
	logic [3:0] nib;
	logic [7:0] pulses = 8'h00;
	int         n_mismatch = 0, tests_run = 0;
	localparam logic [47:0] A = DEFAULT_ADDR;
	mpw_phy_model phy (.clk(clk), .nib(nib), .vld(vld));
	mpw_detector #(.CLIENT_ADDR(A)) DUT (.clk(clk), .rst_n(rst_n), .monitored_nibble(nib),
		.monitored_nibble_valid(vld), .wake_interrupt_pulse(wake));
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) if (wake === 1'b1) pulses <= pulses + 8'h01;
	task automatic check(input logic [7:0] exp);
		tests_run++;
		if (pulses !== exp) $display("mismatch %0t exp %h got %h", $time, exp, pulses);
		n_mismatch += (pulses !== exp);
		pulses = 8'h00;
	endtask
	task automatic results();
		$display("mismatches %0d checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic good_pair();
		phy.frame(12, A, 16); phy.frame(12, A, 16); check(8'h02);
	endtask
	task automatic bad_sync();
		phy.frame(11, A, 16); check(8'h00);
	endtask
	task automatic bad_addr();
		phy.frame(12, A ^ 48'h1, 16); check(8'h00);
	endtask
	task automatic few_reps();
		phy.frame(12, A, 15); check(8'h00);
	endtask
	// a recognizer that skipped the gap would still match the addresses
	task automatic gap_abort();
		phy.frame(12, A, 0); phy.frame(0, A, 16); check(8'h00);
	endtask
	task automatic reset_abort();
		repeat (12) phy.put(SYNC_NIBBLE);
		fork
			phy.frame(0, A, 16);
			begin
				@(negedge clk) rst_n = 1'b0;
				@(negedge clk) rst_n = 1'b1;
			end
		join
		check(8'h00);
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		good_pair(); bad_sync(); bad_addr(); few_reps(); gap_abort(); reset_abort();
		results();
	end
	// all frames take about 7.2 us; about fourteen times that is a hang
	initial begin #100000; n_mismatch++; results(); end
endmodule // mpw_detector_test
`default_nettype wire

// ---- mpw_nibble_cmp.sv ----
// module: selects one address nibble by position and compares it
`default_nettype none
module mpw_nibble_cmp
	import mpw_pkg::*;
(
	// address and position
	input  wire logic [47:0] station_addr,
	input  wire logic [3:0]  pos,
	// nibble under test
	input  wire logic [3:0]  nibble,
	output logic             match
);
	logic [3:0] expect_nibble;
	logic [7:0] addr_byte;

	// bytes go out first-to-last on the wire, low nibble of each byte first
	always_comb begin
		addr_byte     = station_addr[(ADDR_W - 8) - 8 * (32'(pos) >> 1) +: 8];
		expect_nibble = pos[0] ? addr_byte[7:4] : addr_byte[3:0]; // [RQ13]
		match         = (nibble == expect_nibble); // [RQ5]
	end
endmodule // mpw_nibble_cmp
`default_nettype wire

// ---- mpw_phy_model.sv ----
// model: physical layer source of the monitored nibble stream
`default_nettype none
module mpw_phy_model import mpw_pkg::*; (
	input  wire logic       clk,
	output var  logic [3:0] nib,
	output var  logic       vld
);
	timeunit 1ns / 1ps;
	initial {nib, vld} = 5'h00;
	task automatic put(input logic [3:0] x);
		@(negedge clk) {nib, vld} = {x, 1'b1};
	endtask
	// data toggles in gaps so a stale nibble never passes for a good one
	task automatic frame(input int ones, input logic [47:0] a, input int reps);
		repeat (ones) put(SYNC_NIBBLE);
		if (ones == 11) put(4'he);
		repeat (reps) for (int b = 40; b >= 0; b -= 8) begin
			put(a[b +: 4]);
			put(a[b + 4 +: 4]);
		end
		repeat (3) @(negedge clk) {nib, vld} = {~nib, 1'b0};
	endtask
endmodule // mpw_phy_model
`default_nettype wire

// ---- mpw_pkg.sv ----
// package: constants for the magic packet wake detector
`default_nettype none
package mpw_pkg;
	localparam int unsigned NIBBLE_W     = 4;
	localparam int unsigned ADDR_W       = 48;
	localparam int unsigned ADDR_NIBBLES = 12;
	localparam int unsigned SYNC_NIBBLES = 12;
	localparam int unsigned REPEATS      = 16;
	localparam int unsigned POS_W        = 4;
	localparam int unsigned CNT_W        = 5;
	localparam logic [3:0]  SYNC_NIBBLE  = 4'hf;
	localparam logic [3:0]  POS_ZERO     = 4'h0;
	localparam logic [3:0]  POS_LAST     = 4'hb;
	localparam logic [4:0]  CNT_ZERO     = 5'h00;
	localparam logic [4:0]  CNT_DONE     = 5'h10;
	localparam logic [4:0]  CNT_ONE      = 5'h01;
	localparam logic [3:0]  POS_ONE      = 4'h1;
	// default station address, arbitrary value
	localparam logic [47:0] DEFAULT_ADDR = 48'h0a_1b_2c_3d_4e_5f;

	typedef enum logic [2:0] {
		MPW_IDLE = 3'b001,
		MPW_SYNC = 3'b010,
		MPW_ADDR = 3'b100
	} mpw_state_t;
endpackage : mpw_pkg
`default_nettype wire
